// [bench/core_stream_model.sv]
`timescale 1ns/1ps
module core_stream_model (
  input  wire logic       clk,
  output logic            memValid,
  output logic            memIsLoad,
  output dwu_pkg::core_t  memCore,
  output dwu_pkg::word_t  memAddr,
  output logic            resValid,
  output dwu_pkg::core_t  resCore,
  output dwu_pkg::word_t  resId
);
  import dwu_pkg::*;
  initial begin
    memValid = 1'b0;
    memIsLoad = 1'b0;
    memCore = '0;
    memAddr = '0;
    resValid = 1'b0;
    resCore = '0;
    resId = '0;
  end
  // one-cycle access; idle lines show the inverse afterwards
  task automatic mem_access(core_t c, logic ld, word_t a);
    @(posedge clk);
    memValid <= 1'b1;
    memIsLoad <= ld;
    memCore <= c;
    memAddr <= a;
    @(posedge clk);
    memValid <= 1'b0;
    memIsLoad <= ~ld;
    memCore <= ~c;
    memAddr <= ~a;
  endtask : mem_access
  task automatic res_access(core_t c, word_t id);
    @(posedge clk);
    resValid <= 1'b1;
    resCore <= c;
    resId <= id;
    @(posedge clk);
    resValid <= 1'b0;
    resCore <= ~c;
    resId <= ~id;
  endtask : res_access
endmodule : core_stream_model

// [bench/debug_watchpoint_unit_tb_top.sv]
`timescale 1ns/1ps
`include "dwu_cfg.svh"
module debug_watchpoint_unit_tb_top;
  import dwu_pkg::*;
  typedef struct {
    core_t c; logic ld; word_t a; word_t ctl; logic h; logic rs;
  } tcase_t;
  logic       clk, rstn, debugMode, irq;
  logic       memValid, memIsLoad, resValid;
  core_t      memCore, resCore;
  word_t      memAddr, resId, wdata, rdata, v;
  addr_t      awaddr, araddr;
  logic [3:0] wstrb, strb;
  logic       awvalid, awready, wvalid, wready, bvalid, bready;
  logic       arvalid, arready, rvalid, rready;
  axi_resp_t  bresp, rresp;
  int         n_mismatch, compares;
  word_t      rdQ[$];
  axi_resp_t  rrQ[$], wrQ[$];
  reg_idx_t   bases[4];
  tcase_t     tc[12];

  core_stream_model pm (.clk(clk), .memValid(memValid),
    .memIsLoad(memIsLoad), .memCore(memCore), .memAddr(memAddr),
    .resValid(resValid), .resCore(resCore), .resId(resId));
  debug_watchpoint_unit uut (.clk(clk), .rstn(rstn),
    .debugMode(debugMode), .memValid(memValid), .memIsLoad(memIsLoad),
    .memCore(memCore), .memAddr(memAddr), .resValid(resValid),
    .resCore(resCore), .resId(resId), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

  task automatic check(word_t seen, word_t exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic end_test(string s);
    $display("test %s done", s);
  endtask : end_test
  task automatic wr(reg_idx_t idx, word_t d, axi_resp_t r);
    bit aw, w;
    aw = 0;
    w = 0;
    wrQ.push_back(r);
    @(posedge clk);
    awaddr <= addr_t'({idx, 2'b00});
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(reg_idx_t idx, word_t d, axi_resp_t r);
    rdQ.push_back(d);
    rrQ.push_back(r);
    @(posedge clk);
    araddr <= addr_t'({idx, 2'b00});
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // answers are matched against the oldest note
  always @(posedge clk) begin : mon
    word_t e;
    if (rvalid === 1'b1 && rready === 1'b1 && rdQ.size() > 0) begin
      e = rdQ.pop_front();
      if (rrQ[0] === `RESP_OKAY)
        check(rdata, e);
      check(word_t'(rresp), word_t'(rrQ.pop_front()));
    end
    if (bvalid === 1'b1 && bready === 1'b1 && wrQ.size() > 0)
      check(word_t'(bresp), word_t'(wrQ.pop_front()));
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rstn = 1'b0;
    debugMode = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    strb = 4'hf;
    bases = '{`IDX_DADDR1, `IDX_DADDR2, `IDX_RMASK, `IDX_RVALUE};
    tc = '{'{3, 0, 32'h1800, 32'h00080001, 1, 0},
           '{2, 0, 32'h1800, 32'h00080001, 0, 0},
           '{3, 1, 32'h1800, 32'h00080001, 0, 0},
           '{3, 1, 32'h1800, 32'h00080005, 1, 0},
           '{3, 0, 32'h3000, 32'h00080001, 0, 0},
           '{3, 0, 32'h3000, 32'h00080003, 1, 0},
           '{7, 0, 32'h1000, 32'h00800001, 1, 0},
           '{3, 0, 32'h1800, 32'h00080000, 0, 0},
           '{0, 0, 32'h1234562a, 32'h00010001, 1, 1},
           '{0, 0, 32'h12345600, 32'h00010001, 0, 1},
           '{0, 0, 32'h12345600, 32'h00010003, 1, 1},
           '{1, 0, 32'h1234562a, 32'h00010001, 0, 1}};
    void'($urandom(69));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (reg_idx_t i = 0; i < 4; i++) begin
      rd(`IDX_DCTRL + i, '0, `RESP_OKAY);
      rd(`IDX_RCTRL + i, '0, `RESP_OKAY);
    end
    rd(`IDX_STATUS, '0, `RESP_OKAY);
    end_test("reset");
    foreach (bases[b])
      for (reg_idx_t i = 0; i < 4; i++) begin
        v = $urandom();
        wr(bases[b] + i, v, `RESP_OKAY);
        rd(bases[b] + i, v, `RESP_OKAY);
      end
    wr(`IDX_DCTRL + 8'h3, 32'hffffffff, `RESP_OKAY);
    rd(`IDX_DCTRL + 8'h3, `DCTRL_MASK, `RESP_OKAY);
    wr(`IDX_RCTRL + 8'h3, 32'hffffffff, `RESP_OKAY);
    rd(`IDX_RCTRL + 8'h3, `RCTRL_MASK, `RESP_OKAY);
    wr(`IDX_DCTRL + 8'h3, '0, `RESP_OKAY);
    wr(`IDX_RCTRL + 8'h3, '0, `RESP_OKAY);
    end_test("registers");
    wr(`IDX_DADDR1, 32'h1000, `RESP_OKAY);
    @(posedge clk);
    debugMode <= 1'b0;
    wr(`IDX_DADDR1, 32'h5, `RESP_SLVERR);
    wr(`IDX_DADDR2, 32'h7, `RESP_SLVERR);
    rd(`IDX_DADDR1, 32'h1000, `RESP_OKAY);
    @(posedge clk);
    debugMode <= 1'b1;
    wr(`IDX_DADDR1 + 8'h1, 32'h11223344, `RESP_OKAY);
    strb = 4'h6;
    wr(`IDX_DADDR1 + 8'h1, 32'haabbccdd, `RESP_OKAY);
    strb = 4'hf;
    rd(`IDX_DADDR1 + 8'h1, 32'h11bbcc44, `RESP_OKAY);
    wr(`IDX_CAUSE, 32'hffffffff, `RESP_OKAY);
    rd(`IDX_CAUSE, `CAUSE_MASK, `RESP_OKAY);
    wr(`IDX_CAPTURE, 32'h5a5a0f0f, `RESP_OKAY);
    rd(`IDX_CAPTURE, 32'h5a5a0f0f, `RESP_OKAY);
    wr(8'h10, 32'h1, `RESP_DECERR);
    rd(8'h10, '0, `RESP_DECERR);
    wr(`IDX_STATUS, 32'h3, `RESP_OKAY);
    rd(`IDX_CLEAR, '0, `RESP_OKAY);
    rd(`IDX_STATUS, '0, `RESP_OKAY);
    end_test("access");
    wr(`IDX_DADDR2, 32'h1fff, `RESP_OKAY);
    wr(`IDX_RMASK + 8'h1, 32'hff, `RESP_OKAY);
    wr(`IDX_RVALUE + 8'h1, 32'h2a, `RESP_OKAY);
    wr(`IDX_ENABLE, 32'h3, `RESP_OKAY);
    foreach (tc[n]) begin
      if (tc[n].rs) begin
        wr(`IDX_RCTRL + 8'h1, tc[n].ctl, `RESP_OKAY);
        pm.res_access(tc[n].c, tc[n].a);
      end else begin
        wr(`IDX_DCTRL, tc[n].ctl, `RESP_OKAY);
        pm.mem_access(tc[n].c, tc[n].ld, tc[n].a);
      end
      repeat (2) @(posedge clk);
      check(word_t'(irq), word_t'(tc[n].h));
      v = tc[n].h ? (tc[n].rs ? 32'h2 : 32'h1) : 32'h0;
      rd(`IDX_STATUS, v, `RESP_OKAY);
      if (tc[n].h) begin
        v = word_t'(tc[n].rs ? `CAUSE_RES : `CAUSE_DATA);
        v = v | (word_t'(tc[n].c) << 8) | (word_t'(tc[n].rs) << 16);
        rd(`IDX_CAUSE, v, `RESP_OKAY);
        rd(`IDX_CAPTURE, tc[n].a, `RESP_OKAY);
        wr(`IDX_CLEAR, 32'h3, `RESP_OKAY);
      end
    end
    wr(`IDX_RCTRL + 8'h1, 32'h00010000, `RESP_OKAY);
    pm.res_access(0, 32'h1234562a);
    rd(`IDX_STATUS, '0, `RESP_OKAY);
    end_test("watch");
    wr(`IDX_DCTRL, 32'h00080001, `RESP_OKAY);
    wr(`IDX_ENABLE, '0, `RESP_OKAY);
    pm.mem_access(3, 0, 32'h1800);
    repeat (2) @(posedge clk);
    check(word_t'(irq), '0);
    rd(`IDX_STATUS, 32'h1, `RESP_OKAY);
    wr(`IDX_ENABLE, 32'h1, `RESP_OKAY);
    @(posedge clk);
    check(word_t'(irq), 32'h1);
    rd(`IDX_ENABLE, 32'h1, `RESP_OKAY);
    wr(`IDX_CLEAR, 32'h1, `RESP_OKAY);
    @(posedge clk);
    check(word_t'(irq), '0);
    rd(`IDX_STATUS, '0, `RESP_OKAY);
    end_test("interrupt");
    give_verdict();
  end
endmodule : debug_watchpoint_unit_tb_top

// [rtl/axil_slave_port.sv]
`timescale 1ns/1ps
`include "dwu_cfg.svh"
module axil_slave_port (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire dwu_pkg::addr_t      awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire dwu_pkg::word_t      wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output dwu_pkg::axi_resp_t       bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire dwu_pkg::addr_t      araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output dwu_pkg::word_t           rdata,
  output dwu_pkg::axi_resp_t       rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  reg_access_if.bus                regs
);
  import dwu_pkg::*;

  logic       awHeld;
  logic       wHeld;
  addr_t      awAddrHeld;
  word_t      wDataHeld;
  logic [3:0] wStrbHeld;

  wire logic awTake      = awvalid && awready;
  wire logic wTake       = wvalid && wready;
  wire logic arTake      = arvalid && arready;
  // address and data may arrive in either order
  wire logic doWrite     = awHeld && wHeld && !bvalid;
  wire logic next_awHeld = !doWrite && (awHeld || awTake);
  wire logic next_wHeld  = !doWrite && (wHeld || wTake);
  wire logic next_rvalid = arTake || (rvalid && !rready);

  assign regs.wrEn   = doWrite;
  assign regs.wrAddr = awAddrHeld;
  assign regs.wrData = wDataHeld;
  assign regs.wrStrb = wStrbHeld;
  assign regs.rdAddr = araddr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddrHeld <= '0;
      wDataHeld  <= '0;
      wStrbHeld  <= '0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      arready    <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= `RESP_OKAY;
    end else begin
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awready <= !next_awHeld;
      wready  <= !next_wHeld;
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (awTake)
        awAddrHeld <= awaddr;
      if (wTake) begin
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= regs.wrResp;
      end else if (bready)
        bvalid <= 1'b0;
      if (arTake) begin
        rdata <= regs.rdData;
        rresp <= regs.rdResp;
      end
    end
  end

  property p_bvalid_holds;
    @(posedge clk) disable iff (!rstn)
      bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bvalid_holds: assert property (p_bvalid_holds)
    else $error("write response dropped before bready");
endmodule : axil_slave_port

// [rtl/debug_watchpoint_unit.sv]
`timescale 1ns/1ps
`include "dwu_cfg.svh"
module debug_watchpoint_unit (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               debugMode,
  input  wire logic               memValid,
  input  wire logic               memIsLoad,
  input  wire dwu_pkg::core_t     memCore,
  input  wire dwu_pkg::word_t     memAddr,
  input  wire logic               resValid,
  input  wire dwu_pkg::core_t     resCore,
  input  wire dwu_pkg::word_t     resId,
  input  wire dwu_pkg::addr_t     awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire dwu_pkg::word_t     wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output dwu_pkg::axi_resp_t      bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire dwu_pkg::addr_t     araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output dwu_pkg::word_t          rdata,
  output dwu_pkg::axi_resp_t      rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic                    irq
);
  import dwu_pkg::*;

  reg_access_if acc ();

  axil_slave_port busPort (
    .clk     (clk),
    .rstn    (rstn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (acc.bus)
  );

  function automatic logic inBank(input reg_idx_t idx,
                                  input reg_idx_t base);
    return idx >= base && idx <= base + 8'h03;
  endfunction : inBank

  function automatic word_t mergeBytes(input word_t old,
                                       input word_t val,
                                       input logic [3:0] strb);
    word_t res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b])
        res[8*b +: 8] = val[8*b +: 8];
    end
    return res;
  endfunction : mergeBytes

  function automatic logic [1:0] lowest(input logic [3:0] hits);
    if (hits[0])
      return 2'h0;
    else if (hits[1])
      return 2'h1;
    else if (hits[2])
      return 2'h2;
    else
      return 2'h3;
  endfunction : lowest

  word_t      firstAddr  [4];
  word_t      secondAddr [4];
  word_t      dCtrl      [4];
  word_t      rMask      [4];
  word_t      rValue     [4];
  word_t      rCtrl      [4];
  word_t      cause;
  word_t      capture;
  logic [1:0] status;
  logic [1:0] enable;
  logic [3:0] dHits;
  logic [3:0] rHits;
  word_t      rdWord;
  logic       rdMapped;

  // write decode
  wire reg_idx_t   wIdx    = acc.wrAddr[9:2];
  wire word_t      wData   = acc.wrData;
  wire logic [3:0] wStrb   = acc.wrStrb;
  wire logic       wInWin  = acc.wrAddr[11:10] == 2'h0;
  wire logic       wIrqReg = wIdx == `IDX_STATUS || wIdx == `IDX_CLEAR ||
                             wIdx == `IDX_ENABLE;
  wire logic       wWatch  = inBank(wIdx, `IDX_DADDR1) ||
                             inBank(wIdx, `IDX_DADDR2) ||
                             inBank(wIdx, `IDX_DCTRL) ||
                             inBank(wIdx, `IDX_RMASK) ||
                             inBank(wIdx, `IDX_RVALUE) ||
                             inBank(wIdx, `IDX_RCTRL) ||
                             wIdx == `IDX_CAUSE || wIdx == `IDX_CAPTURE;
  wire logic       wMapped = wInWin && (wWatch || wIrqReg);
  // watch registers only accept writes in debug mode
  wire logic       wAllow  = wMapped && (debugMode || wIrqReg);
  wire logic       wDo     = acc.wrEn && wAllow;

  assign acc.wrResp = !wMapped ? `RESP_DECERR :
                      wAllow   ? `RESP_OKAY : `RESP_SLVERR;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gWatch
      wire logic slotSel = wDo && wIdx[1:0] == 2'(g);

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          firstAddr[g]  <= '0;
          secondAddr[g] <= '0;
          dCtrl[g]      <= '0;
          rMask[g]      <= '0;
          rValue[g]     <= '0;
          rCtrl[g]      <= '0;
        end else if (slotSel) begin
          if (inBank(wIdx, `IDX_DADDR1))
            firstAddr[g] <= mergeBytes(firstAddr[g], wData, wStrb);
          if (inBank(wIdx, `IDX_DADDR2))
            secondAddr[g] <= mergeBytes(secondAddr[g], wData, wStrb);
          if (inBank(wIdx, `IDX_DCTRL))
            dCtrl[g] <= mergeBytes(dCtrl[g], wData, wStrb) & `DCTRL_MASK;
          if (inBank(wIdx, `IDX_RMASK))
            rMask[g] <= mergeBytes(rMask[g], wData, wStrb);
          if (inBank(wIdx, `IDX_RVALUE))
            rValue[g] <= mergeBytes(rValue[g], wData, wStrb);
          if (inBank(wIdx, `IDX_RCTRL))
            rCtrl[g] <= mergeBytes(rCtrl[g], wData, wStrb) & `RCTRL_MASK;
        end
      end

      watch_match #(
        .RESOURCE (1'b0)
      ) dataMatch (
        .ctrl     (dCtrl[g]),
        .refA     (firstAddr[g]),
        .refB     (secondAddr[g]),
        .accValid (memValid),
        .accLoad  (memIsLoad),
        .accCore  (memCore),
        .accWord  (memAddr),
        .hit      (dHits[g])
      );

      watch_match #(
        .RESOURCE (1'b1)
      ) resMatch (
        .ctrl     (rCtrl[g]),
        .refA     (rMask[g]),
        .refB     (rValue[g]),
        .accValid (resValid),
        .accLoad  (1'b0),
        .accCore  (resCore),
        .accWord  (resId),
        .hit      (rHits[g])
      );
    end
  endgenerate

  // read decode
  wire reg_idx_t rIdx = acc.rdAddr[9:2];
  wire logic [1:0] rSlot = rIdx[1:0];

  always_comb begin
    rdWord   = '0;
    rdMapped = 1'b1;
    if (acc.rdAddr[11:10] != 2'h0)
      rdMapped = 1'b0;
    else if (inBank(rIdx, `IDX_DADDR1))
      rdWord = firstAddr[rSlot];
    else if (inBank(rIdx, `IDX_DADDR2))
      rdWord = secondAddr[rSlot];
    else if (inBank(rIdx, `IDX_DCTRL))
      rdWord = dCtrl[rSlot];
    else if (inBank(rIdx, `IDX_RMASK))
      rdWord = rMask[rSlot];
    else if (inBank(rIdx, `IDX_RVALUE))
      rdWord = rValue[rSlot];
    else if (inBank(rIdx, `IDX_RCTRL))
      rdWord = rCtrl[rSlot];
    else if (rIdx == `IDX_CAUSE)
      rdWord = cause;
    else if (rIdx == `IDX_CAPTURE)
      rdWord = capture;
    else if (rIdx == `IDX_STATUS)
      rdWord = {30'h0, status};
    else if (rIdx == `IDX_CLEAR)
      rdWord = '0;
    else if (rIdx == `IDX_ENABLE)
      rdWord = {30'h0, enable};
    else
      rdMapped = 1'b0;
  end

  assign acc.rdData = rdWord;
  assign acc.rdResp = rdMapped ? `RESP_OKAY : `RESP_DECERR;

  // hit capture, data watchpoints win over resource ones
  wire logic  dAny     = |dHits;
  wire logic  rAny     = |rHits;
  wire core_t hitCore  = dAny ? memCore : resCore;
  wire logic [1:0] hitNum = dAny ? lowest(dHits) : lowest(rHits);
  wire logic [2:0] hitCode = dAny ? `CAUSE_DATA : `CAUSE_RES;
  wire word_t hitCause = {14'h0, hitNum, 8'(hitCore), 5'h0, hitCode};
  wire word_t hitData  = dAny ? memAddr : resId;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cause   <= '0;
      capture <= '0;
    end else if (dAny || rAny) begin
      cause   <= hitCause;
      capture <= hitData;
    end else if (wDo && wIdx == `IDX_CAUSE)
      cause <= mergeBytes(cause, wData, wStrb) & `CAUSE_MASK;
    else if (wDo && wIdx == `IDX_CAPTURE)
      capture <= mergeBytes(capture, wData, wStrb);
  end

  // sticky events, set wins over a clear in the same cycle
  wire logic       clrWr  = wDo && wIdx == `IDX_CLEAR && wStrb[0];
  wire logic [1:0] clrBits = clrWr ? wData[1:0] : 2'h0;
  wire logic       enWr   = wDo && wIdx == `IDX_ENABLE && wStrb[0];
  wire logic [1:0] next_status = {rAny, dAny} | (status & ~clrBits);
  wire logic [1:0] next_enable = enWr ? wData[1:0] : enable;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= 2'h0;
      enable <= 2'h0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      irq    <= |(next_status & next_enable);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_dataHit;
    dAny;
  endsequence
  sequence s_resOnly;
    rAny && !dAny;
  endsequence
  sequence s_dataHitKept;
    (dAny && enable[0]) ##1 $stable(enable);
  endsequence

  property p_cause_data;
    s_dataHit |=> cause[2:0] == `CAUSE_DATA &&
                  cause[17:16] == $past(lowest(dHits));
  endproperty
  a_cause_data: assert property (p_cause_data)
    else $error("data hit cause wrong");

  property p_cause_res;
    s_resOnly |=> cause[2:0] == `CAUSE_RES &&
                  cause[15:8] == 8'($past(resCore));
  endproperty
  a_cause_res: assert property (p_cause_res)
    else $error("resource hit cause wrong");

  property p_capture_data;
    s_dataHit |=> capture == $past(memAddr);
  endproperty
  a_capture_data: assert property (p_capture_data)
    else $error("data hit address not captured");

  property p_capture_res;
    s_resOnly |=> capture == $past(resId);
  endproperty
  a_capture_res: assert property (p_capture_res)
    else $error("resource id not captured");

  property p_core_gate;
    dHits[0] |-> dCtrl[0][`BIT_ARM] &&
                 dCtrl[0][`CORE_LSB + int'(memCore)];
  endproperty
  a_core_gate: assert property (p_core_gate)
    else $error("data hit from unarmed watch or core");

  property p_load_gate;
    dHits[0] && memIsLoad |-> dCtrl[0][`BIT_LOADS];
  endproperty
  a_load_gate: assert property (p_load_gate)
    else $error("load hit without load enable");

  property p_and_cond;
    dHits[0] && !dCtrl[0][`BIT_SELECT] |->
      memAddr >= firstAddr[0] && memAddr <= secondAddr[0];
  endproperty
  a_and_cond: assert property (p_and_cond)
    else $error("and condition violated");

  property p_res_cond;
    rHits[1] |-> rCtrl[1][`BIT_ARM] &&
      (((resId & rMask[1]) == rValue[1]) != rCtrl[1][`BIT_SELECT]);
  endproperty
  a_res_cond: assert property (p_res_cond)
    else $error("resource condition violated");

  property p_locked_write;
    !debugMode && acc.wrEn && wIdx == `IDX_DADDR2 |=>
      $stable(secondAddr[0]);
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("address written outside debug mode");

  property p_second_write;
    wDo && wIdx == `IDX_DADDR2 && wStrb == 4'hf |=>
      secondAddr[0] == $past(wData);
  endproperty
  a_second_write: assert property (p_second_write)
    else $error("second address not stored");

  property p_irq_raise;
    s_dataHitKept |-> status[0] && irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("enabled data hit did not raise irq");
endmodule : debug_watchpoint_unit

// [rtl/dwu_cfg.svh]
`ifndef DWU_CFG_SVH
`define DWU_CFG_SVH
// Overview of operation
// - four second-address registers, indices 0x60 up
// - data control bit 0 arms watchpoint
// - data control bits 23:16 enable cores
// - data control bit 2 lets loads trigger
// - data bit 1: zero AND, one OR
// - four resource mask registers, indices 0x80 up
// - four resource value registers, indices 0x90 up
// - resource control bits 23:16 enable cores
// - resource bit 1 picks condition A or B
// - resource control bit 0 arms watchpoint
// - four first-address registers, indices 0x50 up
// - cause code 4 data, 5 resource
// - data hit captures effective address
// - resource hit captures resource identifier

`define IDX_DADDR1  8'h50
`define IDX_DADDR2  8'h60
`define IDX_DCTRL   8'h70
`define IDX_RMASK   8'h80
`define IDX_RVALUE  8'h90
`define IDX_RCTRL   8'h9c
`define IDX_CAUSE   8'h15
`define IDX_CAPTURE 8'h16
`define IDX_STATUS  8'ha0
`define IDX_CLEAR   8'ha1
`define IDX_ENABLE  8'ha2

`define BIT_ARM     0
`define BIT_SELECT  1
`define BIT_LOADS   2
`define CORE_LSB    16

`define DCTRL_MASK  32'h00ff0007
`define RCTRL_MASK  32'h00ff0003
`define CAUSE_MASK  32'h0003ff07
`define CAUSE_DATA  3'h4
`define CAUSE_RES   3'h5

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`endif

// [rtl/dwu_pkg.sv]
package dwu_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
  typedef logic [7:0]  reg_idx_t;
  typedef logic [1:0]  axi_resp_t;
  typedef logic [2:0]  core_t;
endpackage : dwu_pkg

// [rtl/reg_access_if.sv]
`timescale 1ns/1ps
interface reg_access_if;
  import dwu_pkg::*;
  logic      wrEn;
  addr_t     wrAddr;
  word_t     wrData;
  logic [3:0] wrStrb;
  axi_resp_t wrResp;
  addr_t     rdAddr;
  word_t     rdData;
  axi_resp_t rdResp;
  modport bus (output wrEn, wrAddr, wrData, wrStrb, rdAddr,
               input wrResp, rdData, rdResp);
  modport regs (input wrEn, wrAddr, wrData, wrStrb, rdAddr,
                output wrResp, rdData, rdResp);
endinterface : reg_access_if

// [rtl/watch_match.sv]
`timescale 1ns/1ps
`include "dwu_cfg.svh"
module watch_match #(
  parameter bit RESOURCE = 1'b0
) (
  input  wire dwu_pkg::word_t ctrl,
  input  wire dwu_pkg::word_t refA,
  input  wire dwu_pkg::word_t refB,
  input  wire logic           accValid,
  input  wire logic           accLoad,
  input  wire dwu_pkg::core_t accCore,
  input  wire dwu_pkg::word_t accWord,
  output logic                hit
);
  import dwu_pkg::*;

  wire logic coreOk   = ctrl[`CORE_LSB + int'(accCore)];
  wire logic armed    = ctrl[`BIT_ARM] && accValid;
  wire logic select   = ctrl[`BIT_SELECT];
  wire logic maskedEq = (accWord & refA) == refB;
  wire logic condA    = RESOURCE ? maskedEq : accWord >= refA;
  wire logic condB    = RESOURCE ? !maskedEq : accWord <= refB;
  // stores always qualify, loads only when allowed
  wire logic loadOk   = RESOURCE || !accLoad || ctrl[`BIT_LOADS];
  wire logic dataCond = select ? (condA || condB) : (condA && condB);
  wire logic resCond  = select ? condB : condA;

  assign hit = armed && coreOk && loadOk && (RESOURCE ? resCond : dataCond);
endmodule : watch_match
